// ### rtl/emb_bus.sv
// external memory bus controller with apb control registers
`timescale 1ns/1ps
`default_nettype none
module emb_bus #(
  parameter int TCY = emb_pkg::TCY_CLKS
) (
  input  wire logic                       mclk_i,
  input  wire logic                       nrst_i,
  // apb slave
  input  wire logic                       psel_i,
  input  wire logic                       penable_i,
  input  wire logic                       pwrite_i,
  input  wire logic [emb_pkg::APB_AW-1:0] paddr_i,
  input  wire logic [31:0]                pwdata_i,
  output logic [31:0]                     prdata_o,
  output logic                            pready_o,
  output logic                            pslverr_o,
  // core side
  input  wire emb_pkg::emb_mode_type      mem_mode_i,
  input  wire logic                       sleep_i,
  input  wire logic                       exec_internal_i,
  input  wire logic                       req_valid_i,
  input  wire emb_pkg::emb_op_type        req_op_i,
  input  wire logic [20:0]                req_addr_i,
  input  wire logic [7:0]                 table_latch_i,
  output logic                            req_ready_o,
  output logic                            rsp_valid_o,
  output logic [15:0]                     rsp_data_o,
  // pins
  input  wire logic [15:0]                muxed_addr_data_i,
  output logic [15:0]                     muxed_addr_data_o,
  output logic                            muxed_addr_data_oe_o,
  output logic [3:0]                      upper_address_o,
  output logic                            upper_address_oe_o,
  output logic                            addr_latch_o,
  output logic                            output_enable_n_o,
  output logic                            chip_enable_n_o,
  output logic                            upper_write_strobe_n_o,
  output logic                            lower_write_strobe_n_o,
  output logic                            upper_byte_enable_n_o,
  output logic                            lower_byte_enable_n_o,
  output logic                            byte_address_lsb_o,
  output logic                            control_oe_o,
  output logic                            port_function_o
);
  import emb_pkg::*;

  // registers
  logic [7:0]    memctl_q;
  logic          dis_eff_q;
  logic          dis_eff_d;
  logic [31:0]   prdata_q;
  emb_state_type state_q;
  emb_state_type state_d;
  emb_op_type    op_q;
  logic [20:0]   addr_q;
  logic [7:0]    latch_q;
  logic [7:0]    held_q;
  logic          rsp_valid_q;
  logic [15:0]   rsp_data_q;
  logic [15:0]   ad_q;
  logic          ad_oe_q;
  logic [3:0]    ua_q;
  logic          ua_oe_q;
  logic          ale_q;
  logic          oe_n_q;
  logic          ce_n_q;
  logic          wrh_n_q;
  logic          wrl_n_q;
  logic          ub_n_q;
  logic          lb_n_q;
  logic          ba0_q;

  // mode decode
  wire int_only   = (mem_mode_i == PM_INT_ONLY);
  wire ext_only   = (mem_mode_i == PM_EXT_ONLY);
  wire mixed_mode = !int_only && !ext_only;

  // apb decode
  wire apb_setup  = psel_i && !penable_i;
  wire apb_access = psel_i && penable_i;
  wire hit_ctl    = (paddr_i == MEMCTL_OFF);
  wire hit_stat   = (paddr_i == STATUS_OFF);
  wire unmapped   = !hit_ctl && !hit_stat;
  // control writes have no effect in internal-only mode
  wire ctl_write  = apb_access && pwrite_i && hit_ctl && !int_only;

  // control fields
  wire       dis_bit      = memctl_q[DIS_BIT];
  wire [1:0] wait_field   = memctl_q[WAIT_LO+1:WAIT_LO];
  wire [1:0] scheme_field = memctl_q[SCHEME_LO+1:SCHEME_LO];

  // control register reads zero in internal-only mode
  wire [7:0] ctl_view = int_only ? 8'h00 : memctl_q;

  wire busy = (state_q != ST_IDLE);

  // external-only keeps the bus, mixed modes follow access/disable
  wire bus_fn = ext_only
              || (mixed_mode && (busy || !dis_eff_q));

  wire [31:0] status_view = {26'h0, busy, bus_fn, dis_eff_q,
                             sleep_i, mem_mode_i};

  wire [31:0] rd_mux = hit_ctl  ? {24'h0, ctl_view} :
                       hit_stat ? status_view : 32'h0;

  // request acceptance
  // internal-only mode never starts a bus cycle
  wire can_take = !busy && !sleep_i && !int_only;
  wire take     = req_valid_i && can_take;
  wire is_read  = (op_q != OP_TABLE_WRITE_OP);

  // wait states
  // field sets the table waits
  wire [1:0]        tbl_waits = emb_waits(wait_field);
  wire [WCNT_W-1:0] tbl_clks  = WCNT_W'(tbl_waits * TCY);
  wire [WCNT_W-1:0] wait_load;
  wire              wait_zero;

  assign wait_load = (req_op_i == OP_FETCH) ? '0 : tbl_clks;

  emb_wait_ctr #(
    .W       (WCNT_W)
  ) u_wait (
    .mclk_i  (mclk_i),
    .nrst_i  (nrst_i),
    .load_i  (take),
    .count_i (wait_load),
    .zero_o  (wait_zero)
  );

  // write lane selection
  wire [15:0] wr_data;
  wire        wr_drive;
  wire        wr_hi;
  wire        wr_lo;
  wire        wr_ub;
  wire        wr_lb;

  emb_write_lane u_lane (
    .scheme_i (scheme_field),
    .lsb_i    (addr_q[0]),
    .latch_i  (latch_q),
    .held_i   (held_q),
    .data_o   (wr_data),
    .drive_o  (wr_drive),
    .wr_hi_o  (wr_hi),
    .wr_lo_o  (wr_lo),
    .ub_o     (wr_ub),
    .lb_o     (wr_lb)
  );

  // even word-write captures the latch byte for its pair
  wire hold_cap = (state_q == ST_DATA) && (op_q == OP_TABLE_WRITE_OP)
               && scheme_field[1] && !addr_q[0];

  // setting the disable bit waits for internal execution
  assign dis_eff_d = !dis_bit ? 1'b0 :
                     exec_internal_i ? 1'b1 : dis_eff_q;

  // cycle sequencer
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (take) state_d = ST_ADDR;
      ST_ADDR: state_d = wait_zero ? ST_DATA : ST_WAIT;
      ST_WAIT: if (wait_zero) state_d = ST_DATA;
      ST_DATA: state_d = ST_IDLE;
    endcase
  end

  // next pin values, one cycle ahead of the pins
  wire n_addr = (state_d == ST_ADDR);
  wire n_wait = (state_d == ST_WAIT);
  wire n_data = (state_d == ST_DATA);
  wire n_cyc  = n_addr || n_wait || n_data;
  wire n_wr   = (n_wait || n_data) && !is_read;
  wire n_rd   = (n_wait || n_data) && is_read;

  wire [20:0] n_addr_v = take ? req_addr_i : addr_q;

  // low address shares the data pins
  wire [15:0] n_ad    = n_addr ? n_addr_v[16:1] : wr_data;
  // even word-write leaves the data phase floating
  wire        n_ad_oe = n_addr || (n_wr && wr_drive);

  // output enable for reads after the address phase
  wire        n_oe_n   = !n_rd;
  // chip enable across the cycle, forced high while asleep
  wire        n_ce_n   = !n_cyc || sleep_i;
  // write strobes only in the data phase
  wire        n_wr_str = n_data && !is_read;
  wire        n_wrh_n  = !(n_wr_str && wr_hi);
  wire        n_wrl_n  = !(n_wr_str && wr_lo);
  // both bytes on reads, scheme choice on writes
  wire        n_ub_n   = !(n_rd || (n_wr && wr_ub));
  wire        n_lb_n   = !(n_rd || (n_wr && wr_lb));
  // byte address kept on its pin for byte-select flash
  wire        n_ba0    = n_cyc && n_addr_v[0];

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      memctl_q <= MEMCTL_RST;
    else if (ctl_write)
      memctl_q <= pwdata_i[7:0] & MEMCTL_MASK;
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dis_eff_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      dis_eff_q <= dis_eff_d;
      if (apb_setup)
        prdata_q <= rd_mux;
    end
  end

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      state_q <= ST_IDLE;
      op_q    <= OP_FETCH;
      addr_q  <= 21'h0;
      latch_q <= 8'h00;
      held_q  <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      if (take)
      begin
        op_q    <= req_op_i;
        addr_q  <= req_addr_i;
        latch_q <= table_latch_i;
      end
      if (hold_cap)
        held_q <= latch_q;
    end
  end

  // read data sampled at the end of the data phase
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0;
    end
    else
    begin
      rsp_valid_q <= (state_q == ST_DATA);
      if ((state_q == ST_DATA) && is_read)
        rsp_data_q <= muxed_addr_data_i;
    end
  end

  // outside a cycle the bus rests at its idle levels
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      ad_q    <= 16'h0;
      ad_oe_q <= 1'b0;
      ua_q    <= 4'h0;
      ua_oe_q <= 1'b0;
      ale_q   <= 1'b0;
      ba0_q   <= 1'b0;
    end
    else
    begin
      ad_q    <= n_ad;
      ad_oe_q <= n_ad_oe;
      // upper address held on its own pins for the cycle
      ua_q    <= n_addr_v[20:17];
      ua_oe_q <= n_cyc;
      // latch strobe during the address phase only
      ale_q   <= n_addr;
      ba0_q   <= n_ba0;
    end
  end

  // control strobes rest high between cycles
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      oe_n_q  <= 1'b1;
      ce_n_q  <= 1'b1;
      wrh_n_q <= 1'b1;
      wrl_n_q <= 1'b1;
      ub_n_q  <= 1'b1;
      lb_n_q  <= 1'b1;
    end
    else
    begin
      oe_n_q  <= n_oe_n;
      ce_n_q  <= n_ce_n;
      wrh_n_q <= n_wrh_n;
      wrl_n_q <= n_wrl_n;
      ub_n_q  <= n_ub_n;
      lb_n_q  <= n_lb_n;
    end
  end

  // apb answers with no wait
  assign pready_o  = 1'b1;
  assign pslverr_o = apb_access && unmapped;
  assign prdata_o  = prdata_q;

  // width is fixed, so nothing here selects it
  assign req_ready_o = can_take;
  assign rsp_valid_o = rsp_valid_q;
  assign rsp_data_o  = rsp_data_q;

  assign muxed_addr_data_o      = ad_q;
  assign muxed_addr_data_oe_o   = ad_oe_q;
  assign upper_address_o        = ua_q;
  assign upper_address_oe_o     = ua_oe_q;
  assign addr_latch_o           = ale_q;
  assign output_enable_n_o      = oe_n_q;
  assign chip_enable_n_o        = ce_n_q;
  assign upper_write_strobe_n_o = wrh_n_q;
  assign lower_write_strobe_n_o = wrl_n_q;
  assign upper_byte_enable_n_o  = ub_n_q;
  assign lower_byte_enable_n_o  = lb_n_q;
  assign byte_address_lsb_o     = ba0_q;

  // pin ownership follows mode, access and disable
  assign control_oe_o    = bus_fn;
  assign port_function_o = !bus_fn;
endmodule : emb_bus
`default_nettype wire

// ### rtl/emb_pkg.sv
// constants and types for the external memory bus controller
// Behaviour
// - external-only mode: bus always active, pins never act as port
// - internal-only mode: bus idle, pins port-only, control writes ignored
// - internal-only mode: control register reads as all zeros
// - mixed modes: external fetch or table access switches pins to bus
// - mixed modes, internal use: bus-disable bit 7, 0 bus, 1 port
// - external access with bus-disable set still takes the pins for bus
// - setting bus-disable from external code waits for branch to internal
// - idle bus: AD and upper address float, strobes high, ALE/BA0 low
// - table wait field bits 5-4: 11=0, 10=1, 01=2, 00=3 waits
// - table write scheme bits 1-0: 1x word, 01 byte select, 00 byte write
// - word write: two latch writes form a word, upper strobe on second
// - byte select: latch byte on both halves, upper strobe plus one enable
// - byte write: latch byte on both halves, strobe chosen by pointer lsb
// - bus is fixed 16 bits wide, no software width control
// - ALE marks address bits 15..0 valid on the shared pins
// - after ALE, output enable reads both bytes as one 16-bit word
// - chip enable low on every access, high while asleep
// - address 15..0 shares pins with data, 19..16 on own pins
// - word write, even address: hold latch byte, float data, no strobe
// - word write, odd address: latch byte high, held byte low, both enabled
package emb_pkg;
  localparam int          APB_AW      = 8;
  localparam logic [7:0]  MEMCTL_OFF  = 8'h00;
  localparam logic [7:0]  STATUS_OFF  = 8'h04;
  localparam logic [7:0]  MEMCTL_RST  = 8'h00;
  localparam logic [7:0]  MEMCTL_MASK = 8'hb3;
  localparam int          DIS_BIT     = 7;
  localparam int          WAIT_LO     = 4;
  localparam int          SCHEME_LO   = 0;
  localparam int          BUS_W       = 16;
  localparam int          UADDR_W     = 4;
  localparam int          WCNT_W      = 8;
  localparam int          TCY_CLKS    = 1;

  typedef enum logic [1:0] {
    PM_EXT_ONLY,
    PM_BOOT_BLOCK,
    PM_EXT_MCU,
    PM_INT_ONLY
  } emb_mode_type;

  typedef enum logic [1:0] {
    OP_FETCH,
    OP_TBLRD,
    OP_TABLE_WRITE_OP
  } emb_op_type;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ADDR,
    ST_WAIT,
    ST_DATA
  } emb_state_type;

  // wait count is the inverse of the field
  function automatic logic [1:0] emb_waits(input logic [1:0] field);
    emb_waits = ~field;
  endfunction : emb_waits
endpackage : emb_pkg

// ### rtl/emb_wait_ctr.sv
// down counter for table cycle wait states
`timescale 1ns/1ps
`default_nettype none
module emb_wait_ctr #(
  parameter int W = 8
) (
  input  wire logic         mclk_i,
  input  wire logic         nrst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] count_i,
  output logic              zero_o
);
  import emb_pkg::*;

  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;

  assign zero_o = (cnt_q == '0);
  assign cnt_d  = load_i ? count_i : (zero_o ? cnt_q : cnt_q - 1'b1);

  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end
endmodule : emb_wait_ctr
`default_nettype wire

// ### rtl/emb_write_lane.sv
// data lanes and strobes of one table write per scheme
`timescale 1ns/1ps
`default_nettype none
module emb_write_lane (
  input  wire logic [1:0]  scheme_i,
  input  wire logic        lsb_i,
  input  wire logic [7:0]  latch_i,
  input  wire logic [7:0]  held_i,
  output logic [15:0]      data_o,
  output logic             drive_o,
  output logic             wr_hi_o,
  output logic             wr_lo_o,
  output logic             ub_o,
  output logic             lb_o
);
  import emb_pkg::*;

  wire word_mode = scheme_i[1];
  wire bsel_mode = (scheme_i == 2'b01);

  // odd half of a word pair carries the held byte low
  assign data_o  = word_mode ? {latch_i, held_i} : {latch_i, latch_i};
  // even word half floats the bus and strobes nothing
  assign drive_o = !word_mode || lsb_i;
  // upper strobe on the second byte of a word, on every byte select, and on odd byte writes
  assign wr_hi_o = word_mode ? lsb_i : (bsel_mode || lsb_i);
  // byte write picks the strobe by pointer lsb
  assign wr_lo_o = !word_mode && !bsel_mode && !lsb_i;
  // byte select enables one byte by pointer lsb
  assign ub_o    = word_mode ? lsb_i : (!bsel_mode || lsb_i);
  assign lb_o    = word_mode ? lsb_i : (!bsel_mode || !lsb_i);
endmodule : emb_write_lane
`default_nettype wire

// ### bench/emb_assertions.sv
// pin-level assertions for the external memory bus controller
`timescale 1ns/1ps
`default_nettype none
module emb_assertions
  import emb_pkg::*;
(
  input wire logic                  mclk_i,
  input wire logic                  nrst_i,
  input wire emb_pkg::emb_mode_type mem_mode_i,
  input wire logic                  sleep_i,
  input wire logic                  req_valid_i,
  input wire emb_pkg::emb_op_type   req_op_i,
  input wire logic [20:0]           req_addr_i,
  input wire logic                  req_ready_o,
  input wire logic                  rsp_valid_o,
  input wire logic [15:0]           muxed_addr_data_o,
  input wire logic                  muxed_addr_data_oe_o,
  input wire logic [3:0]            upper_address_o,
  input wire logic                  upper_address_oe_o,
  input wire logic                  addr_latch_o,
  input wire logic                  output_enable_n_o,
  input wire logic                  chip_enable_n_o,
  input wire logic                  upper_write_strobe_n_o,
  input wire logic                  lower_write_strobe_n_o,
  input wire logic                  upper_byte_enable_n_o,
  input wire logic                  lower_byte_enable_n_o,
  input wire logic                  byte_address_lsb_o,
  input wire logic                  control_oe_o,
  input wire logic                  port_function_o
);
  logic        take;
  logic [20:0] addr_q;
  logic        fetch;
  assign take  = req_valid_i && req_ready_o;
  assign fetch = take && req_op_i == OP_FETCH;
  always_ff @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      addr_q <= 21'h0;
    else if (take)
      addr_q <= req_addr_i;
  end
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!nrst_i);
  a_idle_pins: assert property (
    chip_enable_n_o |-> !muxed_addr_data_oe_o && !upper_address_oe_o
    && output_enable_n_o && upper_write_strobe_n_o && lower_write_strobe_n_o
    && upper_byte_enable_n_o && lower_byte_enable_n_o && !addr_latch_o
    && !byte_address_lsb_o) else $error("pins not idle outside a cycle");
  a_addr_phase: assert property (
    take |=> addr_latch_o && !chip_enable_n_o && muxed_addr_data_oe_o
    && upper_address_oe_o && muxed_addr_data_o == addr_q[16:1]
    && upper_address_o == addr_q[20:17] && byte_address_lsb_o == addr_q[0])
    else $error("address phase wrong");
  a_oe_follows: assert property (
    fetch |=> ##1 !addr_latch_o && !output_enable_n_o && !muxed_addr_data_oe_o
    && !upper_byte_enable_n_o && !lower_byte_enable_n_o)
    else $error("word read phase wrong");
  a_fetch_time: assert property (
    fetch |=> !rsp_valid_o ##1 !rsp_valid_o ##1 rsp_valid_o)
    else $error("fetch took wait cycles");
  a_sleep_ce: assert property (
    sleep_i [*8] |-> chip_enable_n_o) else $error("chip enable low asleep");
  a_int_only: assert property (
    mem_mode_i == PM_INT_ONLY |-> !req_ready_o && port_function_o)
    else $error("bus active in internal-only mode");
  a_ext_only: assert property (
    mem_mode_i == PM_EXT_ONLY |-> control_oe_o && !port_function_o)
    else $error("port function in external-only mode");
  a_access_bus: assert property (
    !chip_enable_n_o |-> control_oe_o && !port_function_o)
    else $error("access without bus function");
endmodule : emb_assertions
bind emb_bus emb_assertions i_chk (.mclk_i, .nrst_i, .mem_mode_i, .sleep_i,
  .req_valid_i, .req_op_i, .req_addr_i, .req_ready_o, .rsp_valid_o,
  .muxed_addr_data_o, .muxed_addr_data_oe_o, .upper_address_o,
  .upper_address_oe_o, .addr_latch_o, .output_enable_n_o, .chip_enable_n_o,
  .upper_write_strobe_n_o, .lower_write_strobe_n_o, .upper_byte_enable_n_o,
  .lower_byte_enable_n_o, .byte_address_lsb_o, .control_oe_o,
  .port_function_o);
`default_nettype wire

// ### bench/emb_mem_model.sv
// behavioural word-wide memory on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module emb_mem_model (
  input  wire logic        clk_i,
  input  wire logic [15:0] ad_i,
  input  wire logic        ad_oe_i,
  input  wire logic [3:0]  ua_i,
  input  wire logic        ale_i,
  input  wire logic        oe_n_i,
  input  wire logic        ce_n_i,
  input  wire logic [4:0]  ctl_i,
  output logic      [15:0] ad_o,
  output logic      [7:0]  wr_count_o,
  output logic      [15:0] wr_data_o,
  output logic      [4:0]  wr_ctl_o
);
  logic [19:0] addr_q;
  logic [15:0] rd;
  logic [7:0]  cnt_q = 8'h00;
  assign wr_count_o = cnt_q;
  // no pull on the lines, so an undriven bus shows a changing pattern
  assign rd   = addr_q[15:0] ^ 16'hc3a5;
  assign ad_o = ad_oe_i ? ad_i : (!oe_n_i && !ce_n_i) ? rd : ~rd;
  // address captured on ALE, data and controls recorded when either write strobe is low
  always @(posedge clk_i)
  begin
    if (ale_i)
      addr_q <= {ua_i, ad_o};
    if (!ce_n_i && (!ctl_i[4] || !ctl_i[3]))
    begin
      cnt_q      <= cnt_q + 8'h01;
      wr_data_o  <= ad_o;
      wr_ctl_o   <= ctl_i;
    end
  end
endmodule : emb_mem_model
`default_nettype wire

// ### bench/test_external_memory_bus.sv
// self-checking bench for the external memory bus controller
`timescale 1ns/1ps
`default_nettype none
module test_external_memory_bus;
  import emb_pkg::*;
  logic         mclk_i, nrst_i, psel_i, penable_i, pwrite_i, sleep_i, err;
  logic         exec_internal_i, req_valid_i, pready_o, pslverr_o;
  logic         req_ready_o, rsp_valid_o, muxed_addr_data_oe_o;
  logic         upper_address_oe_o, addr_latch_o, output_enable_n_o;
  logic         chip_enable_n_o, upper_write_strobe_n_o, byte_address_lsb_o;
  logic         lower_write_strobe_n_o, upper_byte_enable_n_o;
  logic         lower_byte_enable_n_o, control_oe_o, port_function_o;
  logic [7:0]   paddr_i, table_latch_i, wr_count, c0;
  logic [31:0]  pwdata_i, prdata_o, rd;
  logic [15:0]  rsp_data_o, muxed_addr_data_i, muxed_addr_data_o, q, wr_data;
  logic [3:0]   upper_address_o;
  logic [4:0]   wr_ctl;
  logic [20:0]  req_addr_i;
  emb_mode_type mem_mode_i;
  emb_op_type   req_op_i;
  int           errors, check_count, n;
  logic [1:0]   sch [6] = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd2, 2'd3};
  logic [7:0]   lat [6] = '{8'h3c, 8'h5a, 8'h69, 8'h96, 8'h11, 8'h22};
  logic [20:0]  exw [6] = '{{16'h3c3c, 5'h10}, {16'h5a5a, 5'h09},
    {16'h6969, 5'h0c}, {16'h9696, 5'h0b}, {16'h9696, 5'h0b},
    {16'h2211, 5'h09}};
  emb_bus i_dut (.mclk_i, .nrst_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .mem_mode_i, .sleep_i,
    .exec_internal_i, .req_valid_i, .req_op_i, .req_addr_i, .table_latch_i,
    .req_ready_o, .rsp_valid_o, .rsp_data_o, .muxed_addr_data_i,
    .muxed_addr_data_o, .muxed_addr_data_oe_o, .upper_address_o,
    .upper_address_oe_o, .addr_latch_o, .output_enable_n_o, .chip_enable_n_o,
    .upper_write_strobe_n_o, .lower_write_strobe_n_o, .upper_byte_enable_n_o,
    .lower_byte_enable_n_o, .byte_address_lsb_o, .control_oe_o,
    .port_function_o);
  emb_mem_model i_mem (.clk_i(mclk_i), .ad_i(muxed_addr_data_o),
    .ad_oe_i(muxed_addr_data_oe_o), .ua_i(upper_address_o),
    .ale_i(addr_latch_o), .oe_n_i(output_enable_n_o), .ce_n_i(chip_enable_n_o),
    .ctl_i({upper_write_strobe_n_o, lower_write_strobe_n_o,
      upper_byte_enable_n_o, lower_byte_enable_n_o, byte_address_lsb_o}),
    .ad_o(muxed_addr_data_i), .wr_count_o(wr_count), .wr_data_o(wr_data),
    .wr_ctl_o(wr_ctl));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel_i    <= 1'b1;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge mclk_i);
    penable_i <= 1'b1;
    @(posedge mclk_i);
    while (pready_o !== 1'b1)
      @(posedge mclk_i);
    rd  = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge mclk_i);
  endtask : apb
  task automatic core(input emb_op_type o, input logic [20:0] a,
                      input logic [7:0] b);
    req_valid_i   <= 1'b1;
    req_op_i      <= o;
    req_addr_i    <= a;
    table_latch_i <= b;
    @(posedge mclk_i);
    while (req_ready_o !== 1'b1)
      @(posedge mclk_i);
    req_valid_i <= 1'b0;
    n = 0;
    do
    begin
      @(posedge mclk_i);
      n++;
    end
    while (rsp_valid_o !== 1'b1 && n < 40);
    q = rsp_data_o;
    @(posedge mclk_i);
  endtask : core
  // port function, ready and chip enable seen mid-cycle
  task automatic pins(input logic [2:0] e);
    @(negedge mclk_i);
    chk({port_function_o, req_ready_o, chip_enable_n_o}, e);
    @(posedge mclk_i);
  endtask : pins
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  initial
  begin
    mclk_i = 1'b0;
    forever #4 mclk_i = ~mclk_i;
  end
  initial
  begin
    #100000;
    errors++;
    report_and_stop();
  end
  initial
  begin
    {nrst_i, psel_i, penable_i, pwrite_i, sleep_i, exec_internal_i} = '0;
    {paddr_i, pwdata_i, req_addr_i, table_latch_i, req_valid_i} = '0;
    mem_mode_i  = PM_EXT_ONLY;
    req_op_i    = OP_FETCH;
    errors      = 0;
    check_count = 0;
    repeat (2) @(posedge mclk_i);
    nrst_i <= 1'b1;
    apb(1'b1, 8'h00, 32'hffffffff);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'hb3);
    apb(1'b0, 8'h08, 32'h0);
    chk({rd[30:0], err}, 32'h1);
    $display("test done: registers");
    core(OP_FETCH, 21'h1abcd5, 8'h00);
    chk(q, 16'h5e6a ^ 16'hc3a5);
    for (int w = 0; w < 4; w++)
    begin
      apb(1'b1, 8'h00, w << 4);
      core(OP_TBLRD, 21'h00100, 8'h00);
      chk(n, 6 - w);
      core(OP_FETCH, 21'h00002, 8'h00);
      chk(n, 3);
    end
    $display("test done: waits");
    for (int i = 0; i < 6; i++)
    begin
      c0 = wr_count;
      apb(1'b1, 8'h00, {26'h0, 4'h3, sch[i]});
      core(OP_TABLE_WRITE_OP, 21'h00200 + i, lat[i]);
      chk(wr_count - c0, i != 4);
      chk({wr_data, wr_ctl}, exw[i]);
    end
    $display("test done: write schemes");
    mem_mode_i <= PM_EXT_MCU;
    apb(1'b1, 8'h00, 32'h80);
    pins(3'b011);
    exec_internal_i <= 1'b1;
    @(posedge mclk_i);
    pins(3'b111);
    core(OP_TBLRD, 21'h1fffe, 8'h00);
    chk(q, 16'hffff ^ 16'hc3a5);
    pins(3'b111);
    apb(1'b1, 8'h00, 32'h12);
    pins(3'b011);
    $display("test done: bus disable");
    mem_mode_i <= PM_INT_ONLY;
    apb(1'b1, 8'h00, 32'h21);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    pins(3'b101);
    mem_mode_i <= PM_BOOT_BLOCK;
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h12);
    pins(3'b011);
    mem_mode_i <= PM_EXT_ONLY;
    sleep_i    <= 1'b1;
    repeat (9) @(posedge mclk_i);
    pins(3'b001);
    sleep_i <= 1'b0;
    $display("test done: modes and sleep");
    report_and_stop();
  end
endmodule : test_external_memory_bus
`default_nettype wire
